//--- ecc_fault_result_cfg.svh
// offsets, field positions and constant values of the flash option register group
`ifndef FEOR_CFG_SVH
`define FEOR_CFG_SVH
`define FEOR_OFS_DIVIDER 8'h00
`define FEOR_OFS_STATUS 8'h06
`define FEOR_OFS_INDEX 8'h04
`define FEOR_OFS_RES_HI 8'h0E
`define FEOR_OFS_RES_LO 8'h0F
`define FEOR_OFS_OPTION 8'h10
`define FEOR_OFS_RSV_B 8'h0D
`define FEOR_OFS_RSV_C 8'h11
`define FEOR_OFS_RSV_D 8'h12
`define FEOR_OFS_RSV_E 8'h13
`define FEOR_OFS_IRQ_STAT 8'h20
`define FEOR_OFS_IRQ_MASK 8'h21
`define FEOR_OFS_COMMAND 8'h22
`define FEOR_ST_ACCESS_ERROR_FLAG_BIT 5
`define FEOR_ST_DFAULT_BIT 1
`define FEOR_ST_SFAULT_BIT 0
`define FEOR_IRQ_ACCESS_ERROR_FLAG_BIT 2
`define FEOR_IRQ_DFAULT_BIT 1
`define FEOR_IRQ_SFAULT_BIT 0
`define FEOR_DIV_LOADED_BIT 7
`define FEOR_OPTION_FAULT 8'hFF
`define FEOR_ZERO_WORD 16'h0000
`define FEOR_OPTION_ADDR 23'h7FFF0E
`define FEOR_OPTION_LANE 3'h6
`endif

//--- feor_pkg.sv
// types of the flash option register group
package feor_pkg;
   typedef enum logic [1:0] {
      FEOR_BOOT_REQ = 2'h0,
      FEOR_BOOT_WAIT = 2'h1,
      FEOR_BOOT_DONE = 2'h3
   } feor_boot_type;
   typedef struct packed {
      feor_boot_type boot;
      logic [7:0] option;
      logic [6:0] divider;
      logic div_loaded;
      logic [2:0] index;
      logic [1:0] fault_flags;
      logic access_error_flag;
      logic [7:0] check_bits;
      logic [22:0] fault_global_addr;
      logic [63:0] data;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [7:0] rdata;
      logic irq;
      logic boot_rd;
      logic cmd_go;
   } feor_state_type;
endpackage : feor_pkg

//--- feor_regs.sv
// flash ecc result, option byte and divider-loaded register group
//
// The address-and-strobe port is this design's own decision.
`include "ecc_fault_result_cfg.svh"

// Summary of operation
// - factory reserved registers read all zero and ignore writes
// - result window content selected by three-bit index register
// - index 0 shows check bits, zero bit 7, upper seven address bits
// - index 1 lower address, indexes 2 to 5 the four data words
// - indexes 6 and 7 read zero
// - recorder freezes after capture until software clears the fault flag
// - simultaneous faults record the double-bit fault
// - result bits read only, writes ignored
// - check bits eight for program array, six with top two zero for data array
// - captured data and check bits are raw uncorrected values
// - data-array fault puts its word at index 2, address at index 1
// - option register loaded from the configuration byte after reset release
// - double-bit fault on option phrase sets option register all ones
// - any divider write sets the divider-loaded flag, clear after reset
// - program or erase without loaded divider refused, access error set
module feor_regs (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic irq_out,
   input wire logic sfault_in,
   input wire logic dfault_in,
   input wire logic fault_dflash_in,
   input wire logic [22:0] fault_addr_in,
   input wire logic [7:0] fault_check_in,
   input wire logic [63:0] fault_data_in,
   output logic boot_rd_out,
   input wire logic boot_valid_in,
   input wire logic boot_dfault_in,
   input wire logic [63:0] boot_data_in,
   output logic [6:0] divider_value_out,
   output logic divider_loaded_flag_out,
   output logic cmd_go_out
);
   feor_pkg::feor_state_type s_q;
   feor_pkg::feor_state_type s_d;
   logic wr_status;
   logic [15:0] word;
   logic [1:0] clr;
   logic [2:0] ev;

   always_comb begin
      s_d = s_q;
      word = `FEOR_ZERO_WORD;
      clr = 2'h0;
      ev = 3'h0;
      s_d.cmd_go = 1'b0;
      s_d.boot_rd = 1'b0;
      wr_status = wr_in && (addr_in == `FEOR_OFS_STATUS);
      // option byte fetch after reset release
      case (s_q.boot)
         feor_pkg::FEOR_BOOT_REQ: begin
            s_d.boot_rd = 1'b1;
            s_d.boot = feor_pkg::FEOR_BOOT_WAIT;
         end
         feor_pkg::FEOR_BOOT_WAIT: begin
            s_d.boot_rd = ~boot_valid_in;
            if (boot_valid_in) begin
               s_d.boot = feor_pkg::FEOR_BOOT_DONE;
               if (boot_dfault_in) begin
                  s_d.option = `FEOR_OPTION_FAULT;
               end else begin
                  s_d.option = boot_data_in[8*`FEOR_OPTION_LANE +: 8];
               end
            end
         end
         feor_pkg::FEOR_BOOT_DONE: begin
            s_d.boot = feor_pkg::FEOR_BOOT_DONE;
         end
         default: begin
            s_d.boot = feor_pkg::FEOR_BOOT_REQ;
         end
      endcase
      if (wr_status) begin
         clr[1] = wdata_in[`FEOR_ST_DFAULT_BIT];
         clr[0] = wdata_in[`FEOR_ST_SFAULT_BIT];
         if (wdata_in[`FEOR_ST_ACCESS_ERROR_FLAG_BIT]) begin
            s_d.access_error_flag = 1'b0;
         end
      end
      s_d.fault_flags = s_q.fault_flags & ~clr;
      // capture only while no fault is held, double-bit wins
      if ((s_q.fault_flags == 2'h0) && (sfault_in || dfault_in)) begin
         s_d.fault_flags = dfault_in ? 2'h2 : 2'h1;
         ev[`FEOR_IRQ_DFAULT_BIT] = dfault_in;
         ev[`FEOR_IRQ_SFAULT_BIT] = ~dfault_in;
         s_d.fault_global_addr = fault_addr_in;
         s_d.data = fault_data_in;
         if (fault_dflash_in) begin
            s_d.check_bits = {2'h0, fault_check_in[5:0]};
            s_d.data = {48'h0, fault_data_in[15:0]};
         end else begin
            s_d.check_bits = fault_check_in;
         end
      end
      if (wr_in && (addr_in == `FEOR_OFS_DIVIDER)) begin
         s_d.divider = wdata_in[6:0];
         s_d.div_loaded = 1'b1;
      end
      if (wr_in && (addr_in == `FEOR_OFS_INDEX)) begin
         s_d.index = wdata_in[2:0];
      end
      if (wr_in && (addr_in == `FEOR_OFS_IRQ_MASK)) begin
         s_d.irq_mask = wdata_in[2:0];
      end
      if (wr_in && (addr_in == `FEOR_OFS_COMMAND)) begin
         if (s_q.div_loaded) begin
            s_d.cmd_go = 1'b1;
         end else begin
            s_d.access_error_flag = 1'b1;
            ev[`FEOR_IRQ_ACCESS_ERROR_FLAG_BIT] = 1'b1;
         end
      end
      case (s_q.index)
         3'h0: word = {s_q.check_bits, 1'b0, s_q.fault_global_addr[22:16]};
         3'h1: word = s_q.fault_global_addr[15:0];
         3'h2: word = s_q.data[15:0];
         3'h3: word = s_q.data[31:16];
         3'h4: word = s_q.data[47:32];
         3'h5: word = s_q.data[63:48];
         default: word = `FEOR_ZERO_WORD;
      endcase
      s_d.rdata = 8'h00;
      if (rd_in) begin
         case (addr_in)
            `FEOR_OFS_DIVIDER: s_d.rdata = {s_q.div_loaded, s_q.divider};
            `FEOR_OFS_INDEX: s_d.rdata = {5'h00, s_q.index};
            `FEOR_OFS_STATUS: s_d.rdata = {2'h0, s_q.access_error_flag, 3'h0, s_q.fault_flags};
            `FEOR_OFS_RES_HI: s_d.rdata = word[15:8];
            `FEOR_OFS_RES_LO: s_d.rdata = word[7:0];
            `FEOR_OFS_OPTION: s_d.rdata = s_q.option;
            `FEOR_OFS_IRQ_STAT: s_d.rdata = {5'h00, s_q.irq_stat};
            `FEOR_OFS_IRQ_MASK: s_d.rdata = {5'h00, s_q.irq_mask};
            `FEOR_OFS_RSV_B, `FEOR_OFS_RSV_C, `FEOR_OFS_RSV_D, `FEOR_OFS_RSV_E: s_d.rdata = 8'h00;
            default: s_d.rdata = 8'h00;
         endcase
      end
      // read clears status, a new event in the same cycle wins
      if (rd_in && (addr_in == `FEOR_OFS_IRQ_STAT)) begin
         s_d.irq_stat = ev;
      end else begin
         s_d.irq_stat = s_q.irq_stat | ev;
      end
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_out = s_q.rdata;
   assign irq_out = s_q.irq;
   assign boot_rd_out = s_q.boot_rd;
   assign divider_value_out = s_q.divider;
   assign divider_loaded_flag_out = s_q.div_loaded;
   assign cmd_go_out = s_q.cmd_go;
endmodule : feor_regs

//--- feor_regs_properties.sv
// port assertions of the flash option register group
module feor_regs_properties (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic boot_rd_out,
   input wire logic boot_valid_in,
   input wire logic [6:0] divider_value_out,
   input wire logic divider_loaded_flag_out,
   input wire logic cmd_go_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   a_rsv_reads_zero: assert property ($past(rd_in) && $past(addr_in) inside {8'h0D, 8'h11, 8'h12, 8'h13}
      |-> rdata_out == 8'h00) else $error("reserved read not zero");
   a_div_write_loads: assert property (wr_in && addr_in == 8'h00 |=> divider_loaded_flag_out
      && {1'h0, divider_value_out} == ($past(wdata_in) & 8'h7F)) else $error("divider not loaded");
   a_div_flag_sticky: assert property (divider_loaded_flag_out |=> divider_loaded_flag_out)
      else $error("divider flag dropped");
   a_div_read_back: assert property ($past(rd_in) && $past(addr_in) == 8'h00
      |-> rdata_out == {$past(divider_loaded_flag_out), $past(divider_value_out)}) else $error("divider read");
   a_cmd_refused: assert property (wr_in && addr_in == 8'h22 && !divider_loaded_flag_out |=> !cmd_go_out)
      else $error("command ran without divider");
   a_cmd_needs_div: assert property (cmd_go_out |-> divider_loaded_flag_out)
      else $error("command without divider");
   a_boot_req_hold: assert property (boot_rd_out && !boot_valid_in |=> boot_rd_out)
      else $error("option fetch dropped");
   a_boot_req_end: assert property (boot_rd_out && boot_valid_in |=> !boot_rd_out)
      else $error("option fetch stuck");
   c_cmd_go: cover property (cmd_go_out);
   c_boot: cover property (boot_rd_out && boot_valid_in);
   c_rsv_read: cover property (rd_in && addr_in == 8'h11);
endmodule : feor_regs_properties

//--- tb.sv
// self-checking bench of the flash option register group
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'h0, resetn_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0, sfault_in = 1'h0, dfault_in = 1'h0;
   logic fault_dflash_in = 1'h0, boot_valid_in = 1'h0, boot_dfault_in = 1'h0;
   logic irq_out, boot_rd_out, divider_loaded_flag_out, cmd_go_out;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, fault_check_in = 8'h00, rdata_out;
   logic [22:0] fault_addr_in = 23'h000000;
   logic [63:0] fault_data_in = 64'h0, boot_data_in = 64'h0;
   logic [6:0] divider_value_out;
   logic [15:0] w [8];
   logic [7:0] ra [4] = '{8'h0D, 8'h11, 8'h12, 8'h13};
   int checks = 0, miscompares = 0;
   feor_regs feor_regs_inst (.core_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
      .sfault_in, .dfault_in, .fault_dflash_in, .fault_addr_in, .fault_check_in, .fault_data_in, .boot_rd_out,
      .boot_valid_in, .boot_dfault_in, .boot_data_in, .divider_value_out, .divider_loaded_flag_out, .cmd_go_out);
   initial begin
      forever #20 core_clk_in = ~core_clk_in;
   end
   task ck(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : ck
   task conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      wr_in <= 1'h1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge core_clk_in);
      wr_in <= 1'h0;
      #1;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_in);
      rd_in <= 1'h1;
      addr_in <= a;
      @(posedge core_clk_in);
      rd_in <= 1'h0;
      #1 ck(rdata_out, e);
   endtask : rd
   // every result index, both bytes
   task win;
      for (int i = 0; i < 8; i++) begin
         wr(8'h04, 8'(i));
         rd(8'h0E, w[i][15:8]);
         rd(8'h0F, w[i][7:0]);
      end
   endtask : win
   task flt(input logic s, d, df, input logic [22:0] a, input logic [7:0] c, input logic [63:0] dt);
      @(posedge core_clk_in);
      {sfault_in, dfault_in, fault_dflash_in} <= {s, d, df};
      {fault_addr_in, fault_check_in, fault_data_in} <= {a, c, dt};
      @(posedge core_clk_in);
      {sfault_in, dfault_in} <= 2'h0;
   endtask : flt
   task boot(input logic df, input logic [7:0] e);
      resetn_in <= 1'h0;
      repeat (5) @(posedge core_clk_in);
      resetn_in <= 1'h1;
      for (int i = 0; i < 20 && boot_rd_out !== 1'h1; i++) begin
         @(posedge core_clk_in);
         #1;
      end
      if (boot_rd_out !== 1'h1) begin
         miscompares++;
         $display("ERROR %0t option fetch request never raised", $time);
         conclude;
      end
      @(posedge core_clk_in);
      {boot_valid_in, boot_dfault_in, boot_data_in} <= {1'h1, df, 64'h00A5_0000_0000_0000};
      @(posedge core_clk_in);
      boot_valid_in <= 1'h0;
      rd(8'h10, e);
   endtask : boot
   initial begin
      boot(1'h0, 8'hA5);
      wr(8'h10, 8'h00);
      rd(8'h10, 8'hA5);
      rd(8'h00, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(ra[i], 8'hFF);
         rd(ra[i], 8'h00);
      end
      wr(8'h21, 8'h07);
      wr(8'h22, 8'h00);
      ck(cmd_go_out, 1'h0);
      rd(8'h06, 8'h20);
      ck(irq_out, 1'h1);
      rd(8'h20, 8'h04);
      ck(irq_out, 1'h0);
      wr(8'h00, 8'h13);
      rd(8'h00, 8'h93);
      wr(8'h06, 8'h20);
      wr(8'h22, 8'h00);
      ck(cmd_go_out, 1'h1);
      flt(1'h1, 1'h1, 1'h0, 23'h5ABCDE, 8'hC3, {4{16'h3C96}});
      flt(1'h0, 1'h1, 1'h0, 23'h012345, 8'h11, 64'h0);
      wr(8'h0E, 8'hFF);
      wr(8'h0F, 8'hFF);
      w = '{16'hC35A, 16'hBCDE, 16'h3C96, 16'h3C96, 16'h3C96, 16'h3C96, 16'h0000, 16'h0000};
      win;
      wr(8'h06, 8'h03);
      flt(1'h1, 1'h0, 1'h1, 23'h100246, 8'hFF, 64'hFFFF_FFFF_FFFF_1234);
      w = '{16'h3F10, 16'h0246, 16'h1234, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      win;
      boot(1'h1, 8'hFF);
      conclude;
   end
endmodule : tb
bind feor_regs feor_regs_properties feor_regs_properties_inst (.core_clk_in, .resetn_in, .addr_in, .wdata_in,
   .wr_in, .rd_in, .rdata_out, .boot_rd_out, .boot_valid_in, .divider_value_out, .divider_loaded_flag_out, .cmd_go_out);
